/* rtl/ivm_defines.vh */
// Constants for the interrupt vector map block
`ifndef IVM_DEFINES_VH
`define IVM_DEFINES_VH

// ****************************************
// Request space
// ****************************************
`define IVM_NREQ        151
`define IVM_PRI_W       3
`define IVM_VEC_OFS     8'h08
`define IVM_TBL_BASE    24'h000014
`define IVM_RESET_ADDR  24'h000000
`define IVM_FLAG_BITS   16
`define IVM_PRI_SLOTS   4
`define IVM_NIB_W       4

// ****************************************
// Implemented sources
// ****************************************
`define IVM_IMPL_BASE  151'h7e_c000_0000_0000_0000_200e_0006_0073_ff1f_7fff
`define IVM_IMPL_CAN   151'h40_0000_000c_0000_0000
`define IVM_IMPL_MOTOR 151'h1_c000_0000_0600_0000_0000_0000

// ****************************************
// Register map (byte addresses)
// ****************************************
`define IVM_AW          12
`define IVM_FLAG_BASE   12'h000
`define IVM_FLAG_NUM    10
`define IVM_EN_BASE     12'h040
`define IVM_EN_NUM      10
`define IVM_PRI_BASE    12'h080
`define IVM_PRI_NUM     38
`define IVM_STAT_ADDR   12'h200
`define IVM_CLR_ADDR    12'h204
`define IVM_IEN_ADDR    12'h208
`define IVM_VSTAT_ADDR  12'h20c
`define IVM_LKUP_ADDR   12'h210
`define IVM_INFO0_ADDR  12'h214
`define IVM_INFO1_ADDR  12'h218

// ****************************************
// Field layout
// ****************************************
`define IVM_NEV         2
`define IVM_EV_NEWVEC   0
`define IVM_EV_OVERRUN  1
`define IVM_VS_VALID    15
`define IVM_VS_LVL_LSB  8
`define IVM_I1_REG_LSB  4
`define IVM_I1_PREG_LSB 8
`define IVM_I1_PBIT_LSB 16
`define IVM_I0_VEC_LSB  24

`endif

/* rtl/ivm_sync.v */
// Two-stage synchroniser with rising edge pulse per request line
`timescale 1ns/1ps
module ivm_sync #(
    parameter W = 151
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire [W-1:0] din,
    output wire [W-1:0] rise
);
    reg [W-1:0] meta;
    reg [W-1:0] sync;
    reg [W-1:0] last;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= {W{1'b0}};
            sync <= {W{1'b0}};
            last <= {W{1'b0}};
        end else begin
            meta <= din;
            sync <= meta;
            last <= sync;
        end
    end

    assign rise = sync & ~last;
endmodule

/* rtl/ivm_arbiter.v */
// Priority arbiter: highest level wins, lowest request number on a tie
`timescale 1ns/1ps
module ivm_arbiter #(
    parameter N  = 151,
    parameter PW = 3
) (
    input  wire [N-1:0]    cand,
    input  wire [N*PW-1:0] pri,
    output reg             found,
    output reg  [7:0]      idx,
    output reg  [PW-1:0]   level
);
    integer n;

    always @* begin
        found = 1'b0;
        idx   = 8'h00;
        level = {PW{1'b0}};
        // Strict compare keeps the lower number on equal level
        for (n = 0; n < N; n = n + 1) begin
            if (cand[n] && (!found || pri[n*PW +: PW] > level)) begin
                found = 1'b1;
                idx   = n[7:0];
                level = pri[n*PW +: PW];
            end
        end
    end
endmodule

/* rtl/ivm_vector_map.v */
// Interrupt vector map: request flags, enables, priorities, arbitration
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "ivm_defines.vh"
module ivm_vector_map #(
    parameter HAS_CAN   = 1,
    parameter HAS_MOTOR = 1
) (
    input  wire                     pclk,
    input  wire                     presetn,
    input  wire                     psel,
    input  wire                     penable,
    input  wire                     pwrite,
    input  wire [`IVM_AW-1:0]       paddr,
    input  wire [31:0]              pwdata,
    output reg  [31:0]              prdata,
    output reg                      pready,
    output reg                      pslverr,
    input  wire [`IVM_NREQ-1:0]     src_req,
    output reg                      cpu_irq_valid,
    output reg  [7:0]               cpu_vector_num,
    output reg  [23:0]              cpu_vector_addr,
    output reg  [`IVM_PRI_W-1:0]    cpu_irq_level,
    output reg                      cpu_pc_zero,
    output reg  [23:0]              cpu_reset_addr,
    output reg                      irq
);
    localparam N  = `IVM_NREQ;
    localparam PW = `IVM_PRI_W;

    // ****************************************
    // Address decode
    // ****************************************
    function hit;
        input [`IVM_AW-1:0] a;
        input [`IVM_AW-1:0] base;
        input integer       num;
        begin
            hit = (a >= base) && (a < base + num * 4) && (a[1:0] == 2'b00);
        end
    endfunction

    function integer widx;
        input [`IVM_AW-1:0] a;
        input [`IVM_AW-1:0] base;
        begin
            widx = (a - base) >> 2;
        end
    endfunction

    // ****************************************
    // Variant source set
    // ****************************************
    wire [N-1:0] impl;
    assign impl = `IVM_IMPL_BASE
        | (HAS_CAN   != 0 ? `IVM_IMPL_CAN   : {N{1'b0}})
        | (HAS_MOTOR != 0 ? `IVM_IMPL_MOTOR : {N{1'b0}});

    // ****************************************
    // State
    // ****************************************
    reg  [N-1:0]        request_flag_reg;
    reg  [N-1:0]        request_enable_reg;
    reg  [N*PW-1:0]     request_priority_reg;
    reg  [`IVM_NEV-1:0] status;
    reg  [`IVM_NEV-1:0] ien;
    reg  [7:0]          lookup;
    reg                 entry;
    reg  [N-1:0]        next_flag;
    reg  [N-1:0]        next_en;
    reg  [N*PW-1:0]     next_pri;
    reg  [N-1:0]        cand;
    reg  [31:0]         rdata;
    reg                 rerr;
    wire [N-1:0]        src_rise;
    wire                found;
    wire [7:0]          win_idx;
    wire [PW-1:0]       win_lvl;
    wire                acc;
    wire                wr_go;
    wire                rd_go;

    assign acc   = psel & penable;
    assign wr_go = acc & pready & pwrite;
    assign rd_go = acc & ~pready;

    ivm_sync #(
        .W (N)
    ) u_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .din   (src_req),
        .rise  (src_rise)
    );

    // ****************************************
    // Flag, enable and priority update
    // ****************************************
    integer b;
    integer n;
    integer k;

    always @* begin
        next_flag = request_flag_reg;
        next_en   = request_enable_reg;
        next_pri  = request_priority_reg;
        k = 0;
        n = 0;
        if (wr_go && hit(paddr, `IVM_FLAG_BASE, `IVM_FLAG_NUM)) begin
            k = widx(paddr, `IVM_FLAG_BASE);
            for (b = 0; b < `IVM_FLAG_BITS; b = b + 1) begin
                n = k * `IVM_FLAG_BITS + b;
                if (n < N) begin
                    next_flag[n] = pwdata[b];
                end
            end
        end
        if (wr_go && hit(paddr, `IVM_EN_BASE, `IVM_EN_NUM)) begin
            k = widx(paddr, `IVM_EN_BASE);
            for (b = 0; b < `IVM_FLAG_BITS; b = b + 1) begin
                n = k * `IVM_FLAG_BITS + b;
                if (n < N) begin
                    next_en[n] = pwdata[b];
                end
            end
        end
        if (wr_go && hit(paddr, `IVM_PRI_BASE, `IVM_PRI_NUM)) begin
            k = widx(paddr, `IVM_PRI_BASE);
            for (b = 0; b < `IVM_PRI_SLOTS; b = b + 1) begin
                n = k * `IVM_PRI_SLOTS + b;
                if (n < N) begin
                    next_pri[n*PW +: PW] =
                        pwdata[b*`IVM_NIB_W +: PW];
                end
            end
        end
        // Source edge wins over a software clear in the same cycle
        next_flag = (next_flag | src_rise) & impl;
        next_en   = next_en & impl;
        for (n = 0; n < N; n = n + 1) begin
            if (!impl[n]) begin
                next_pri[n*PW +: PW] = {PW{1'b0}};
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            request_flag_reg     <= {N{1'b0}};
            request_enable_reg   <= {N{1'b0}};
            request_priority_reg <= {(N*PW){1'b0}};
        end else begin
            request_flag_reg     <= next_flag;
            request_enable_reg   <= next_en;
            request_priority_reg <= next_pri;
        end
    end

    // ****************************************
    // Arbitration
    // ****************************************
    always @* begin
        for (n = 0; n < N; n = n + 1) begin
            cand[n] = request_flag_reg[n] & request_enable_reg[n]
                & impl[n] & (|request_priority_reg[n*PW +: PW]);
        end
    end

    ivm_arbiter #(
        .N  (N),
        .PW (PW)
    ) u_arb (
        .cand  (cand),
        .pri   (request_priority_reg),
        .found (found),                                           
        .idx   (win_idx),
        .level (win_lvl)
    );

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            entry           <= 1'b1;
            cpu_pc_zero     <= 1'b1;
            cpu_reset_addr  <= `IVM_RESET_ADDR;
            cpu_irq_valid   <= 1'b0;
            cpu_vector_num  <= 8'h00;
            cpu_vector_addr <= 24'h000000;
            cpu_irq_level   <= {PW{1'b0}};
        end else begin
            entry          <= 1'b0;
            cpu_pc_zero    <= entry;
            cpu_reset_addr <= `IVM_RESET_ADDR;
            // No arbitration while reset entry is in progress
            cpu_irq_valid  <= found & ~entry;
            if (found && !entry) begin
                cpu_vector_num  <= win_idx + `IVM_VEC_OFS;
                cpu_vector_addr <= `IVM_TBL_BASE
                    + {15'h0000, win_idx, 1'b0};
                cpu_irq_level   <= win_lvl;
            end
        end
    end

    // ****************************************
    // Event status and interrupt
    // ****************************************
    wire [`IVM_NEV-1:0] ev;
    wire [`IVM_NEV-1:0] clr;
    wire [`IVM_NEV-1:0] next_status;
    wire [`IVM_NEV-1:0] next_ien;

    assign ev[`IVM_EV_NEWVEC]  = found & ~entry & (~cpu_irq_valid
        | (win_idx + `IVM_VEC_OFS != cpu_vector_num));
    assign ev[`IVM_EV_OVERRUN] = |(src_rise & request_flag_reg & impl);
    assign clr = (wr_go && paddr == `IVM_CLR_ADDR)
        ? pwdata[`IVM_NEV-1:0] : {`IVM_NEV{1'b0}};
    assign next_status = (status & ~clr) | ev;
    assign next_ien = (wr_go && paddr == `IVM_IEN_ADDR)
        ? pwdata[`IVM_NEV-1:0] : ien;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= {`IVM_NEV{1'b0}};
            ien    <= {`IVM_NEV{1'b0}};
            lookup <= 8'h00;
            irq    <= 1'b0;
        end else begin
            status <= next_status;
            ien    <= next_ien;
            irq    <= |(next_status & next_ien);
            if (wr_go && paddr == `IVM_LKUP_ADDR) begin
                lookup <= pwdata[7:0];
            end
        end
    end

    // ****************************************
    // Location lookup for one request
    // ****************************************
    wire        lk_ok;
    wire [31:0] info0;
    wire [31:0] info1;

    assign lk_ok = (lookup < N) && impl[lookup];
    assign info0 = lk_ok ? {lookup + `IVM_VEC_OFS,
        `IVM_TBL_BASE + {15'h0000, lookup, 1'b0}} : 32'h00000000;
    assign info1 = lk_ok ? {11'h000,
        {1'b0, lookup[1:0], 2'b00},
        2'b00, lookup[7:2],
        lookup[7:4],
        lookup[3:0]} : 32'h00000000;

    // ****************************************
    // APB read path
    // ****************************************
    always @* begin
        rdata = 32'h00000000;
        rerr  = 1'b0;
        k = 0;
        n = 0;
        if (hit(paddr, `IVM_FLAG_BASE, `IVM_FLAG_NUM)) begin
            k = widx(paddr, `IVM_FLAG_BASE);
            for (b = 0; b < `IVM_FLAG_BITS; b = b + 1) begin
                n = k * `IVM_FLAG_BITS + b;
                if (n < N) begin
                    rdata[b] = request_flag_reg[n];
                end
            end
        end else if (hit(paddr, `IVM_EN_BASE, `IVM_EN_NUM)) begin
            k = widx(paddr, `IVM_EN_BASE);
            for (b = 0; b < `IVM_FLAG_BITS; b = b + 1) begin
                n = k * `IVM_FLAG_BITS + b;
                if (n < N) begin
                    rdata[b] = request_enable_reg[n];
                end
            end
        end else if (hit(paddr, `IVM_PRI_BASE, `IVM_PRI_NUM)) begin
            k = widx(paddr, `IVM_PRI_BASE);
            for (b = 0; b < `IVM_PRI_SLOTS; b = b + 1) begin
                n = k * `IVM_PRI_SLOTS + b;
                if (n < N) begin
                    rdata[b*`IVM_NIB_W +: PW] =
                        request_priority_reg[n*PW +: PW];
                end
            end
        end else if (paddr == `IVM_STAT_ADDR) begin
            rdata[`IVM_NEV-1:0] = status;
        end else if (paddr == `IVM_CLR_ADDR) begin
            rdata = 32'h00000000;
        end else if (paddr == `IVM_IEN_ADDR) begin
            rdata[`IVM_NEV-1:0] = ien;
        end else if (paddr == `IVM_VSTAT_ADDR) begin
            rdata[`IVM_VS_VALID] = cpu_irq_valid;
            rdata[`IVM_VS_LVL_LSB +: PW] = cpu_irq_level;
            rdata[7:0] = cpu_vector_num;
        end else if (paddr == `IVM_LKUP_ADDR) begin
            rdata[7:0] = lookup;
        end else if (paddr == `IVM_INFO0_ADDR) begin
            rdata = info0;
        end else if (paddr == `IVM_INFO1_ADDR) begin
            rdata = info1;
        end else begin
            rerr = 1'b1;
        end
    end

    // One wait state: ready rises in the second access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= rd_go;
            pslverr <= rd_go & rerr;
            prdata  <= (rd_go && !pwrite) ? rdata : 32'h00000000;
        end
    end
endmodule

/* tb/ivm_checker_properties.sv */
// Checker for the interrupt vector map block
`timescale 1ns/1ps
module ivm_checker (
    input logic        pclk,
    input logic        presetn,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [11:0] paddr,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    input logic        cpu_irq_valid,
    input logic [7:0]  cpu_vector_num,
    input logic [23:0] cpu_vector_addr,
    input logic        cpu_pc_zero,
    input logic [23:0] cpu_reset_addr,
    input logic        irq
);
    logic acc;
    logic wr;
    assign acc = psel && penable && pready;
    assign wr  = acc && pwrite;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ****************************************
    // Properties
    // ****************************************
    property p_rst_addr;
        cpu_reset_addr == 24'h000000;
    endproperty
    a_rst_addr: assert property (p_rst_addr)
        else $error("reset address not zero");
    property p_pc_zero;
        $past(presetn) && $past(presetn, 2) |-> !cpu_pc_zero;
    endproperty
    a_pc_zero: assert property (p_pc_zero)
        else $error("fetch restart held too long");
    property p_no_arb;
        cpu_pc_zero |-> !cpu_irq_valid;
    endproperty
    a_no_arb: assert property (p_no_arb)
        else $error("vector offered during reset entry");
    property p_vec_addr;
        cpu_irq_valid |->
            cpu_vector_addr == {15'h0, cpu_vector_num, 1'h0} + 24'h000004;
    endproperty
    a_vec_addr: assert property (p_vec_addr)
        else $error("table address does not match vector");
    property p_rsv;
        cpu_irq_valid |-> !(cpu_vector_num inside {[8'h00:8'h07], 8'h17,
            [8'h1d:8'h1f], [8'h2f:8'h38], [8'h3b:8'h40], [8'h43:8'h48],
            8'h4c, 8'h4d, [8'h4f:8'h54], [8'h56:8'h65], [8'h69:8'h95],
            8'h98, [8'h9f:8'hff]});
    endproperty
    a_rsv: assert property (p_rsv)
        else $error("reserved vector offered");
    property p_hold;
        cpu_irq_valid && !wr && !$past(wr) |=> cpu_irq_valid;
    endproperty
    a_hold: assert property (p_hold)
        else $error("pending request vanished without software");
    property p_irq_hold;
        irq && !wr && !$past(wr) |=> irq;
    endproperty
    a_irq_hold: assert property (p_irq_hold)
        else $error("interrupt dropped without software");
    property p_pri_nib;
        acc && !pwrite && paddr inside {[12'h080:12'h114]} |->
            prdata[31:16] == 16'h0 && (prdata[15:0] & 16'h8888) == 16'h0;
    endproperty
    a_pri_nib: assert property (p_pri_nib)
        else $error("unused priority bit reads one");
    property p_err;
        acc |-> pslverr == !(paddr inside {[12'h000:12'h024],
            [12'h040:12'h064], [12'h080:12'h114], [12'h200:12'h218]});
    endproperty
    a_err: assert property (p_err)
        else $error("error response on wrong address");
endmodule

/* tb/ivm_periph_model.sv */
// Requesting peripheral model driving the source lines
`timescale 1ns/1ps
module ivm_periph_model (
    input  logic         pclk,
    input  logic         fire,
    input  logic [7:0]   num,
    output logic [150:0] src_req
);
    logic [2:0] age = 3'h0;
    initial src_req = '0;
    // Raise one line, release all lines a few cycles later
    always @(posedge pclk) begin
        if (fire) begin
            src_req[num] <= 1'h1;
            age <= 3'h0;
        end else if (age == 3'h4) begin
            src_req <= '0;
        end else begin
            age <= age + 3'h1;
        end
    end
endmodule

/* tb/testbench.sv */
// Testbench for the interrupt vector map block
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic [31:0] d;
        logic [31:0] m;
        logic        e;
    } ivm_note_t;
    logic         pclk, presetn, psel, penable, pwrite, fire;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata;
    logic         pready, pslverr, cpu_irq_valid, cpu_pc_zero, irq;
    logic [7:0]   cpu_vector_num, num;
    logic [23:0]  cpu_vector_addr, cpu_reset_addr;
    logic [2:0]   cpu_irq_level, p;
    logic [150:0] src_req;
    logic [31:0]  seed = 32'h0000956e;
    ivm_note_t    notes[$];
    ivm_note_t    nt;
    int           n_mismatch = 0;
    int           check_count = 0;
    int           n;
    int           srcs[11] = '{0, 4, 14, 24, 36, 49, 57, 65, 70, 77, 150};
    ivm_vector_map dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .src_req(src_req), .cpu_irq_valid(cpu_irq_valid),
        .cpu_vector_num(cpu_vector_num), .cpu_vector_addr(cpu_vector_addr),
        .cpu_irq_level(cpu_irq_level), .cpu_pc_zero(cpu_pc_zero),
        .cpu_reset_addr(cpu_reset_addr), .irq(irq));
    ivm_periph_model peer (.pclk(pclk), .fire(fire), .num(num),
        .src_req(src_req));
    // ****************************************
    // Tasks
    // ****************************************
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [31:0] ex,
                       input logic [31:0] m);
        int t;
        t = 0;
        notes.push_back('{ex, m, a > 12'h218});
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1 && t < 40) begin
            @(posedge pclk);
            t++;
        end
        if (t >= 40)
            n_mismatch++;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic wreg(input logic [11:0] a, input logic [31:0] d);
        apb(1'h1, a, d, 32'h0, 32'h0);
    endtask
    task automatic rreg(input logic [11:0] a, input logic [31:0] e,
                        input logic [31:0] m);
        apb(1'h0, a, 32'h0, e, m);
    endtask
    task automatic lkup(input int k, input logic rsv);
        logic [31:0] e0, e1;
        e0 = rsv ? 0 : ((k + 8) << 24) | (20 + 2 * k);
        e1 = rsv ? 0 : ((4 * (k % 4)) << 16) | ((k / 4) << 8)
                       | ((k / 16) << 4) | (k % 16);
        wreg(12'h210, k);
        rreg(12'h214, e0, '1);
        rreg(12'h218, e1, '1);
    endtask
    task automatic arm(input int k, input logic [2:0] lvl);
        wreg(12'h040 + 4 * (k / 16), 1 << (k % 16));
        wreg(12'h080 + 4 * (k / 4), lvl << (4 * (k % 4)));
    endtask
    task automatic fire_req(input int k);
        num <= k;
        fire <= 1'h1;
        @(posedge pclk);
        fire <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ****************************************
    // Clock, monitor, watchdog
    // ****************************************
    initial begin
        pclk = 1'h0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (psel && penable && pready) begin
            nt = notes.pop_front();
            check(prdata & nt.m, nt.d & nt.m);
            check({31'h0, pslverr}, {31'h0, nt.e});
        end
    end
    initial begin
        #200000;
        n_mismatch++;
        tally_and_finish;
    end
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        {presetn, psel, penable, pwrite, fire} = 5'h0;
        {paddr, pwdata, num} = 52'h0;
        repeat (2) @(posedge pclk);
        check(cpu_pc_zero, 1);
        check(cpu_reset_addr, 0);
        check(cpu_irq_valid, 0);
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        rreg(12'h000, 0, '1);
        rreg(12'h080, 0, '1);
        wreg(12'h208, 3);
        foreach (srcs[i]) begin
            n = srcs[i];
            p = xs() % 7 + 1;
            lkup(n, 1'h0);
            arm(n, p);
            fire_req(n);
            for (int t = 0; t < 30 && cpu_irq_valid !== 1'h1; t++)
                @(posedge pclk);
            check(cpu_vector_num, n + 8);
            check(cpu_vector_addr, 20 + 2 * n);
            check(cpu_irq_level, p);
            rreg(12'h000 + 4 * (n / 16), 1 << (n % 16), '1);
            check(irq, 1);
            wreg(12'h000 + 4 * (n / 16), 0);
            @(posedge pclk);
            check(cpu_irq_valid, 0);
            wreg(12'h204, 3);
            rreg(12'h200, 0, 3);
            check(irq, 0);
        end
        wreg(12'h208, 0);
        arm(24, 5);
        arm(36, 5);
        fire_req(36);
        fire_req(24);
        repeat (6) @(posedge pclk);
        check(cpu_vector_num, 32);
        check(irq, 0);
        wreg(12'h208, 3);
        @(posedge pclk);
        check(irq, 1);
        wreg(12'h0a4, 6);
        @(posedge pclk);
        check(cpu_vector_num, 44);
        fire_req(36);
        repeat (4) @(posedge pclk);
        rreg(12'h200, 2, 2);
        wreg(12'h004, 0);
        wreg(12'h008, 0);
        wreg(12'h204, 3);
        lkup(15, 1'h1);
        wreg(12'h040, 32'h0000ffff);
        wreg(12'h08c, 32'h00007777);
        fire_req(15);
        repeat (6) @(posedge pclk);
        check(cpu_irq_valid, 0);
        rreg(12'h000, 0, '1);
        rreg(12'h040, 32'h00007fff, '1);
        rreg(12'h08c, 32'h00000777, '1);
        rreg(12'h300, 0, 0);
        tally_and_finish;
    end
endmodule
bind ivm_vector_map ivm_checker u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_irq_valid(cpu_irq_valid), .cpu_vector_num(cpu_vector_num),
    .cpu_vector_addr(cpu_vector_addr), .cpu_pc_zero(cpu_pc_zero),
    .cpu_reset_addr(cpu_reset_addr), .irq(irq));
